//--- pkg/ebm_params.svh
`ifndef EBM_PARAMS_SVH
`define EBM_PARAMS_SVH
// Array geometry: 512 words of four 9-bit lanes
`define EBM_WORDS      512
`define EBM_MAX_DEPTH  15'h4000
// Register offsets
`define EBM_REG_CTRL   8'h00
`define EBM_REG_LEVEL  8'h04
`define EBM_REG_STATUS 8'h08
// Control fields
`define EBM_F_MODE     2:0
`define EBM_F_WA       5:3
`define EBM_F_WB       8:6
`define EBM_F_ECC      9
`define EBM_F_PIPE_A   10
`define EBM_F_PIPE_B   11
`define EBM_F_AF       14:0
`define EBM_F_AE       30:16
// Reset values
`define EBM_CTRL_RESET 32'h0000_0000
`define EBM_AF_RESET   15'h0100
`define EBM_AE_RESET   15'h0010
`endif

//--- pkg/ebm_pkg.sv
package ebm_pkg;

  typedef enum logic [2:0] {
    EBM_SINGLE      = 3'h0,
    EBM_TRUE_DUAL   = 3'h1,
    EBM_PSEUDO_DUAL = 3'h2,
    EBM_ROM         = 3'h3,
    EBM_FIFO        = 3'h4
  } ebm_mode_t;

  typedef enum logic [2:0] {
    EBM_W1  = 3'h0,
    EBM_W2  = 3'h1,
    EBM_W4  = 3'h2,
    EBM_W9  = 3'h3,
    EBM_W18 = 3'h4,
    EBM_W36 = 3'h5
  } ebm_width_t;

  // Mask of the data bits of one port word
  function automatic logic [35:0] ebm_wmask(input ebm_width_t w);
    unique case (w)
      EBM_W1:  return 36'h0_0000_0001;
      EBM_W2:  return 36'h0_0000_0003;
      EBM_W4:  return 36'h0_0000_000f;
      EBM_W9:  return 36'h0_0000_01ff;
      EBM_W18: return 36'h0_0003_ffff;
      default: return 36'hf_ffff_ffff;
    endcase
  endfunction

  // Bit offset of a port word inside its array word
  function automatic logic [5:0] ebm_pos(input ebm_width_t w,
                                         input logic [13:0] a);
    unique case (w)
      EBM_W1:  return 6'(a[4:3]) * 6'h09 + 6'(a[2:0]);
      EBM_W2:  return 6'(a[3:2]) * 6'h09 + 6'({a[1:0], 1'b0});
      EBM_W4:  return 6'(a[2:1]) * 6'h09 + 6'({a[0], 2'h0});
      EBM_W9:  return 6'(a[1:0]) * 6'h09;
      EBM_W18: return a[0] ? 6'h12 : 6'h00;
      default: return 6'h00;
    endcase
  endfunction

  // Array word holding a port address
  function automatic logic [8:0] ebm_word(input ebm_width_t w,
                                          input logic [13:0] a);
    unique case (w)
      EBM_W1:  return a[13:5];
      EBM_W2:  return a[12:4];
      EBM_W4:  return a[11:3];
      EBM_W9:  return a[10:2];
      EBM_W18: return a[9:1];
      default: return a[8:0];
    endcase
  endfunction

  // Six Hamming bits over positions 1..38 plus overall parity
  function automatic logic [6:0] ebm_ecc_encode(input logic [31:0] d);
    logic [5:0] c;
    int         j;
    c = 6'h00;
    j = 0;
    for (int i = 1; i < 39; i++) begin
      if ((i & (i - 1)) != 0) begin
        if (d[j]) c = c ^ i[5:0];
        j++;
      end
    end
    return {^{d, c}, c};
  endfunction

endpackage

//--- src/ebm_port_out.sv
`timescale 1ns/1ns
module ebm_port_out #(
  parameter bit ASYNC_CLEAR = 1'b0
) (
  // Clock and clear
  input  logic               clk,
  input  logic               clr,
  // Array word and selection
  input  logic               load,
  input  logic [35:0]        word,
  input  logic [6:0]         check,
  input  logic               ecc_en,
  input  ebm_pkg::ebm_width_t width,
  input  logic [5:0]         pos,
  input  logic               pipe_en,
  // Read result
  output logic [35:0]        rdata,
  output logic               single_err,
  output logic               double_err
);
  logic [5:0]  syn;
  logic        overall;
  logic [31:0] fixed;
  logic [35:0] next_latch;
  logic        next_sgl;
  logic        next_dbl;
  logic [35:0] latch;
  logic        sgl;
  logic        dbl;
  logic [35:0] pipe;
  logic        psgl;
  logic        pdbl;

  // Syndrome, single-bit repair and port word extraction
  always_comb begin
    int j;
    j = 0;
    syn = check[5:0];
    for (int i = 1; i < 39; i++) begin
      if ((i & (i - 1)) != 0) begin
        if (word[j]) syn = syn ^ i[5:0];
        j++;
      end
    end
    overall = ^{word[31:0], check};
    fixed = word[31:0];
    j = 0;
    for (int i = 1; i < 39; i++) begin
      if ((i & (i - 1)) != 0) begin
        if (overall && syn == i[5:0]) fixed[j] = ~word[j];
        j++;
      end
    end
    next_sgl = ecc_en & overall;
    next_dbl = ecc_en & ~overall & (syn != 6'h00);
    next_latch = ecc_en ? {4'h0, fixed}
                        : (word >> pos) & ebm_pkg::ebm_wmask(width);
  end

  // Output latch and pipeline stage, cleared in the chosen manner
  generate
    if (ASYNC_CLEAR) begin : g_async
      always_ff @(posedge clk or posedge clr) begin
        if (clr) begin
          latch <= 36'h0_0000_0000;
          sgl   <= 1'b0;
          dbl   <= 1'b0;
          pipe  <= 36'h0_0000_0000;
          psgl  <= 1'b0;
          pdbl  <= 1'b0;
        end else begin
          if (load) begin
            latch <= next_latch;
            sgl   <= next_sgl;
            dbl   <= next_dbl;
          end
          pipe <= latch;
          psgl <= sgl;
          pdbl <= dbl;
        end
      end
    end else begin : g_sync
      always_ff @(posedge clk) begin
        if (clr) begin
          latch <= 36'h0_0000_0000;
          sgl   <= 1'b0;
          dbl   <= 1'b0;
          pipe  <= 36'h0_0000_0000;
          psgl  <= 1'b0;
          pdbl  <= 1'b0;
        end else begin
          if (load) begin
            latch <= next_latch;
            sgl   <= next_sgl;
            dbl   <= next_dbl;
          end
          pipe <= latch;
          psgl <= sgl;
          pdbl <= dbl;
        end
      end
    end
  endgenerate

  // Optional extra cycle of read latency
  assign rdata      = pipe_en ? pipe : latch;
  assign single_err = pipe_en ? psgl : sgl;
  assign double_err = pipe_en ? pdbl : dbl;

  a_clear_out: assert property (@(posedge clk)
    clr |=> rdata == 36'h0_0000_0000 && !single_err && !double_err)
    else $error("output not cleared");
  a_flags_apart: assert property (@(posedge clk) disable iff (clr)
    !(single_err && double_err))
    else $error("both error flags set");
  a_pipe_delay: assert property (@(posedge clk) disable iff (clr)
    pipe_en ##1 pipe_en |-> rdata == $past(latch))
    else $error("pipeline latency wrong");
  a_clean_read: assert property (@(posedge clk) disable iff (clr)
    load && ecc_en && syn == 6'h00 && !overall
    |=> latch == {4'h0, $past(word[31:0])} && !sgl && !dbl)
    else $error("clean ecc word altered");
endmodule

//--- src/ebm_block_memory.sv
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`include "ebm_params.svh"
// What this block does
// - 18 kb array, input, output, pipeline stages
// - Selectable single, dual, pseudo dual, ROM, FIFO
// - Shapes 16384x1 to 512x36; dual lacks x36 unless ECC
// - FIFO counters with full, empty, almost flags
// - Ninth bit per byte stored for parity
// - Byte enables limit x18 and x36 writes
// - ECC writes are fixed 32-bit words
// - Check bits stored on write, checked on read
// - Single-bit errors corrected at the output
// - Separate single and double error flags
// - Ports may differ in width, except ECC and FIFO
// - Linear bit order across words, any width
// - Preloaded contents, writes off gives ROM
// - Address and data registered at array input
// - Optional output register adds one cycle
// - Output latches clear asynchronously or synchronously
// - Per-port reset clears only its latches
// - Global active-low reset clears both ports
// - Pipeline registers cleared like the latches
module ebm_block_memory #(
  parameter bit ASYNC_CLEAR = 1'b0
) (
  // Clock and resets
  input  logic        clk,
  input  logic        reset,
  input  logic        global_set_reset_n,
  // Register port
  input  logic [7:0]  reg_addr,
  input  logic [31:0] reg_wdata,
  input  logic        reg_write,
  input  logic        reg_read,
  output logic [31:0] reg_rdata,
  // Content preload
  input  logic        init_load,
  input  logic [8:0]  init_addr,
  input  logic [35:0] init_data,
  // Port A
  input  logic [13:0] port_a_addr,
  input  logic [35:0] port_a_wdata,
  input  logic [3:0]  port_a_byte_en,
  input  logic        port_a_write,
  input  logic        port_a_read,
  input  logic        port_a_output_reset,
  output logic [35:0] port_a_rdata,
  output logic        port_a_single_err,
  output logic        port_a_double_err,
  // Port B
  input  logic [13:0] port_b_addr,
  input  logic [35:0] port_b_wdata,
  input  logic [3:0]  port_b_byte_en,
  input  logic        port_b_write,
  input  logic        port_b_read,
  input  logic        port_b_output_reset,
  output logic [35:0] port_b_rdata,
  output logic        port_b_single_err,
  output logic        port_b_double_err,
  // Buffer flags
  output logic        fifo_full,
  output logic        fifo_almost_full,
  output logic        fifo_empty,
  output logic        fifo_almost_empty
);
  logic [31:0]         ctrl;
  logic [14:0]         af_level;
  logic [14:0]         ae_level;
  ebm_pkg::ebm_mode_t  mode;
  ebm_pkg::ebm_width_t wa;
  ebm_pkg::ebm_width_t wb;
  logic                ecc_en;
  logic                is_fifo;
  logic                is_tdp;
  logic [2:0]          gsr_sync;
  logic                gsr_n;
  logic                clr_a;
  logic                clr_b;
  logic [35:0]         mem [0:`EBM_WORDS-1];
  logic [6:0]          chk_mem [0:`EBM_WORDS-1];
  logic [13:0]         wr_ptr;
  logic [13:0]         rd_ptr;
  logic [14:0]         count;
  logic [14:0]         depth;
  logic                push;
  logic                pop;
  logic [13:0]         a_addr_q;
  logic [35:0]         a_data_q;
  logic [3:0]          a_be_q;
  logic                a_wr_q;
  logic                a_rd_q;
  logic [13:0]         b_addr_q;
  logic [35:0]         b_data_q;
  logic [3:0]          b_be_q;
  logic                b_wr_q;
  logic                b_rd_q;
  logic [8:0]          a_word;
  logic [8:0]          b_word;
  logic [35:0]         a_new;
  logic [35:0]         b_new;

  // Port width after mode limits
  function automatic ebm_pkg::ebm_width_t eff_width(input logic [2:0] code,
                                                    input logic tdp,
                                                    input logic ecc);
    ebm_pkg::ebm_width_t w;
    w = (code > 3'h5) ? ebm_pkg::EBM_W36 : ebm_pkg::ebm_width_t'(code);
    if (ecc) begin
      w = ebm_pkg::EBM_W36;
    end else if (tdp && w == ebm_pkg::EBM_W36) begin
      w = ebm_pkg::EBM_W18;
    end
    return w;
  endfunction

  // New array word after a masked write of one port word
  function automatic logic [35:0] merge(input logic [35:0] old,
                                        input logic [35:0] data,
                                        input ebm_pkg::ebm_width_t w,
                                        input logic [13:0] addr,
                                        input logic [3:0] be,
                                        input logic ecc);
    logic [35:0] m;
    logic [35:0] d;
    logic [3:0]  b;
    b = 4'hf;
    if (w == ebm_pkg::EBM_W18) begin
      b = {be[1:0], be[1:0]};
    end else if (w == ebm_pkg::EBM_W36 && !ecc) begin
      b = be;
    end
    m = ebm_pkg::ebm_wmask(w) << ebm_pkg::ebm_pos(w, addr);
    m = m & {{9{b[3]}}, {9{b[2]}}, {9{b[1]}}, {9{b[0]}}};
    d = ecc ? {4'h0, data[31:0]} : data & ebm_pkg::ebm_wmask(w);
    d = d << ebm_pkg::ebm_pos(w, addr);
    return (old & ~m) | (d & m);
  endfunction

  // Buffer pointer step, wrapping at the depth of the shape
  function automatic logic [13:0] next_ptr(input logic [13:0] p,
                                           input logic [14:0] dep);
    return (15'(p) + 15'h0001 == dep) ? 14'h0000 : p + 14'h0001;
  endfunction

  // Decoded configuration
  assign mode    = ebm_pkg::ebm_mode_t'(ctrl[`EBM_F_MODE]);
  assign ecc_en  = ctrl[`EBM_F_ECC];
  assign is_fifo = mode == ebm_pkg::EBM_FIFO;
  assign is_tdp  = mode == ebm_pkg::EBM_TRUE_DUAL;
  assign wa      = eff_width(ctrl[`EBM_F_WA], is_tdp, ecc_en);
  assign wb      = eff_width(is_fifo ? ctrl[`EBM_F_WA] : ctrl[`EBM_F_WB],
                             is_tdp, ecc_en);

  // Global reset pin synchroniser, accepted when stages two and three agree
  always_ff @(posedge clk) begin
    if (reset) begin
      gsr_sync <= 3'h7;
    end else begin
      gsr_sync <= {gsr_sync[1:0], global_set_reset_n};
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      gsr_n <= 1'b1;
    end else if (gsr_sync[2] == gsr_sync[1]) begin
      gsr_n <= gsr_sync[2];
    end
  end

  // Output clears: local port reset or global reset
  assign clr_a = reset | port_a_output_reset | ~gsr_n;
  assign clr_b = reset | port_b_output_reset | ~gsr_n;

  // Register writes
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl     <= `EBM_CTRL_RESET;
      af_level <= `EBM_AF_RESET;
      ae_level <= `EBM_AE_RESET;
    end else if (reg_write) begin
      if (reg_addr == `EBM_REG_CTRL) begin
        ctrl <= {20'h0_0000, reg_wdata[11:0]};
      end
      if (reg_addr == `EBM_REG_LEVEL) begin
        af_level <= reg_wdata[`EBM_F_AF];
        ae_level <= reg_wdata[`EBM_F_AE];
      end
    end
  end

  // Register reads, data valid only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (reset || !reg_read) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      case (reg_addr)
        `EBM_REG_CTRL:   reg_rdata <= ctrl;
        `EBM_REG_LEVEL:  reg_rdata <= {1'b0, ae_level, 1'b0, af_level};
        `EBM_REG_STATUS: reg_rdata <= {12'h000, fifo_almost_full, fifo_full,
                                       fifo_almost_empty, fifo_empty,
                                       1'b0, count};
        default:         reg_rdata <= 32'h0000_0000;
      endcase
    end
  end

  // Buffer flags from the fill count
  assign depth             = `EBM_MAX_DEPTH >> wa;
  assign fifo_full         = is_fifo && count >= depth;
  assign fifo_empty        = !is_fifo || count == 15'h0000;
  assign fifo_almost_full  = is_fifo && count >= af_level;
  assign fifo_almost_empty = !is_fifo || count <= ae_level;
  assign push              = is_fifo & port_a_write & ~fifo_full;
  assign pop               = is_fifo & port_b_read & ~fifo_empty;

  // Buffer pointers and count, held at zero outside buffer mode
  always_ff @(posedge clk) begin
    if (reset || !is_fifo) begin
      wr_ptr <= 14'h0000;
      rd_ptr <= 14'h0000;
      count  <= 15'h0000;
    end else begin
      if (push) wr_ptr <= next_ptr(wr_ptr, depth);
      if (pop) rd_ptr <= next_ptr(rd_ptr, depth);
      count <= count + 15'(push) - 15'(pop);
    end
  end

  // Port A input registers; ROM and read-only roles drop writes
  always_ff @(posedge clk) begin
    if (reset) begin
      a_addr_q <= 14'h0000;
      a_data_q <= 36'h0_0000_0000;
      a_be_q   <= 4'h0;
      a_wr_q   <= 1'b0;
      a_rd_q   <= 1'b0;
    end else begin
      a_addr_q <= is_fifo ? wr_ptr : port_a_addr;
      a_data_q <= port_a_wdata;
      a_be_q   <= port_a_byte_en;
      a_wr_q   <= is_fifo ? push : port_a_write &&
                  mode inside {ebm_pkg::EBM_SINGLE, ebm_pkg::EBM_TRUE_DUAL,
                               ebm_pkg::EBM_PSEUDO_DUAL};
      a_rd_q   <= port_a_read &&
                  mode inside {ebm_pkg::EBM_SINGLE, ebm_pkg::EBM_TRUE_DUAL,
                               ebm_pkg::EBM_ROM};
    end
  end

  // Port B input registers; reads pop the buffer in buffer mode
  always_ff @(posedge clk) begin
    if (reset) begin
      b_addr_q <= 14'h0000;
      b_data_q <= 36'h0_0000_0000;
      b_be_q   <= 4'h0;
      b_wr_q   <= 1'b0;
      b_rd_q   <= 1'b0;
    end else begin
      b_addr_q <= is_fifo ? rd_ptr : port_b_addr;
      b_data_q <= port_b_wdata;
      b_be_q   <= port_b_byte_en;
      b_wr_q   <= port_b_write && is_tdp;
      b_rd_q   <= is_fifo ? pop : port_b_read &&
                  mode inside {ebm_pkg::EBM_TRUE_DUAL,
                               ebm_pkg::EBM_PSEUDO_DUAL, ebm_pkg::EBM_ROM};
    end
  end

  // Array word selection and merged write words
  assign a_word = ebm_pkg::ebm_word(wa, a_addr_q);
  assign b_word = ebm_pkg::ebm_word(wb, b_addr_q);
  assign a_new  = merge(mem[a_word], a_data_q, wa, a_addr_q, a_be_q, ecc_en);
  assign b_new  = merge(mem[b_word], b_data_q, wb, b_addr_q, b_be_q, ecc_en);

  // Array writes with check bits; port A overrides B on a collision
  always_ff @(posedge clk) begin
    if (init_load) begin
      mem[init_addr]     <= init_data;
      chk_mem[init_addr] <= ebm_pkg::ebm_ecc_encode(init_data[31:0]);
    end
    if (b_wr_q) begin
      mem[b_word]     <= b_new;
      chk_mem[b_word] <= ebm_pkg::ebm_ecc_encode(b_new[31:0]);
    end
    if (a_wr_q) begin
      mem[a_word]     <= a_new;
      chk_mem[a_word] <= ebm_pkg::ebm_ecc_encode(a_new[31:0]);
    end
  end

  // Output stages with ECC check and correction
  ebm_port_out #(
    .ASYNC_CLEAR (ASYNC_CLEAR)
  ) u_out_a (
    .clk        (clk),
    .clr        (clr_a),
    .load       (a_rd_q),
    .word       (mem[a_word]),
    .check      (chk_mem[a_word]),
    .ecc_en     (ecc_en),
    .width      (wa),
    .pos        (ebm_pkg::ebm_pos(wa, a_addr_q)),
    .pipe_en    (ctrl[`EBM_F_PIPE_A]),
    .rdata      (port_a_rdata),
    .single_err (port_a_single_err),
    .double_err (port_a_double_err)
  );

  ebm_port_out #(
    .ASYNC_CLEAR (ASYNC_CLEAR)
  ) u_out_b (
    .clk        (clk),
    .clr        (clr_b),
    .load       (b_rd_q),
    .word       (mem[b_word]),
    .check      (chk_mem[b_word]),
    .ecc_en     (ecc_en),
    .width      (wb),
    .pos        (ebm_pkg::ebm_pos(wb, b_addr_q)),
    .pipe_en    (ctrl[`EBM_F_PIPE_B]),
    .rdata      (port_b_rdata),
    .single_err (port_b_single_err),
    .double_err (port_b_double_err)
  );

  a_full_hold: assert property (@(posedge clk) disable iff (reset)
    is_fifo && fifo_full && !pop |=> $stable(wr_ptr) && $stable(count))
    else $error("write taken while full");
  a_empty_hold: assert property (@(posedge clk) disable iff (reset)
    is_fifo && fifo_empty && port_b_read ##1 is_fifo |-> $stable(rd_ptr))
    else $error("read taken while empty");
  a_fill_flag: assert property (@(posedge clk) disable iff (reset)
    is_fifo && push && !pop && count + 15'h0001 == depth && !reg_write
    |=> fifo_full && !fifo_empty)
    else $error("full flag missing");
  a_rom_quiet: assert property (@(posedge clk) disable iff (reset)
    mode == ebm_pkg::EBM_ROM |=> !a_wr_q && !b_wr_q)
    else $error("write in rom mode");
  a_tdp_width: assert property (@(posedge clk) disable iff (reset)
    is_tdp && !ecc_en |-> wa != ebm_pkg::EBM_W36 && wb != ebm_pkg::EBM_W36)
    else $error("x36 in true dual mode");
  a_ecc_width: assert property (@(posedge clk) disable iff (reset)
    ecc_en |-> wa == ebm_pkg::EBM_W36 && wb == ebm_pkg::EBM_W36)
    else $error("ecc word not 32 bits");
  a_in_capture: assert property (@(posedge clk) disable iff (reset)
    port_a_write && mode == ebm_pkg::EBM_SINGLE
    |=> a_wr_q && a_addr_q == $past(port_a_addr))
    else $error("port a input not captured");
  a_gsr_clear: assert property (@(posedge clk) disable iff (reset)
    !gsr_n |-> clr_a && clr_b)
    else $error("global reset misses a port");
endmodule

//--- bench/ebm_fabric_port.sv
`timescale 1ns/1ns
module ebm_fabric_port (
  // Clock
  input  wire logic        clk,
  // Port drive
  output logic [13:0]      addr,
  output logic [35:0]      wdata,
  output logic [3:0]       byte_en,
  output logic             write,
  output logic             read,
  output logic             output_reset,
  // Port result
  input  wire logic [35:0] rdata
);
  // Idle port at time zero
  initial begin
    {addr, wdata, byte_en, write, read, output_reset} = '0;
  end

  // One write; released data lines show the inverse value
  task automatic wr(input logic [13:0] a, input logic [35:0] d,
                    input logic [3:0] be);
    @(posedge clk);
    {addr, wdata, byte_en, write} <= {a, d, be, 1'b1};
    @(posedge clk);
    {write, wdata} <= {1'b0, ~d};
  endtask

  // One read; extra edges cover the output register stage
  task automatic rd(input logic [13:0] a, input int xtra,
                    output logic [35:0] q);
    @(posedge clk);
    {addr, read} <= {a, 1'b1};
    @(posedge clk);
    read <= 1'b0;
    repeat (1 + xtra) @(posedge clk);
    #1 q = rdata;
  endtask

  // One-cycle local output clear, driven by this port alone
  task automatic clear();
    @(posedge clk);
    output_reset <= 1'b1;
    @(posedge clk);
    output_reset <= 1'b0;
  endtask
endmodule

//--- bench/tb.sv
`timescale 1ns/1ns
module tb;
  localparam logic [35:0] D = 36'h9_8765_4321;
  localparam logic [35:0] M = 36'h0_07fc_01ff;
  logic        clk = 1'b0;
  logic        reset;
  logic        global_set_reset_n;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_write;
  logic        reg_read;
  logic [31:0] reg_rdata;
  logic        init_load;
  logic [8:0]  init_addr;
  logic [35:0] init_data;
  logic [13:0] port_a_addr, port_b_addr;
  logic [35:0] port_a_wdata, port_b_wdata, port_a_rdata, port_b_rdata;
  logic [3:0]  port_a_byte_en, port_b_byte_en;
  logic        port_a_write, port_a_read, port_a_output_reset;
  logic        port_b_write, port_b_read, port_b_output_reset;
  logic        port_a_single_err, port_a_double_err;
  logic        port_b_single_err, port_b_double_err;
  logic        fifo_full, fifo_almost_full, fifo_empty, fifo_almost_empty;
  logic [35:0] q;
  int          fail_count = 0;
  int          total_checks = 0;

  // Device and the two fabric ports
  ebm_block_memory i_dut (.clk, .reset, .global_set_reset_n, .reg_addr,
    .reg_wdata, .reg_write, .reg_read, .reg_rdata, .init_load, .init_addr,
    .init_data, .port_a_addr, .port_a_wdata, .port_a_byte_en, .port_a_write,
    .port_a_read, .port_a_output_reset, .port_a_rdata, .port_a_single_err,
    .port_a_double_err, .port_b_addr, .port_b_wdata, .port_b_byte_en,
    .port_b_write, .port_b_read, .port_b_output_reset, .port_b_rdata,
    .port_b_single_err, .port_b_double_err, .fifo_full, .fifo_almost_full,
    .fifo_empty, .fifo_almost_empty);
  ebm_fabric_port i_pa (.clk, .addr(port_a_addr), .wdata(port_a_wdata),
    .byte_en(port_a_byte_en), .write(port_a_write), .read(port_a_read),
    .output_reset(port_a_output_reset), .rdata(port_a_rdata));
  ebm_fabric_port i_pb (.clk, .addr(port_b_addr), .wdata(port_b_wdata),
    .byte_en(port_b_byte_en), .write(port_b_write), .read(port_b_read),
    .output_reset(port_b_output_reset), .rdata(port_b_rdata));

  // Clock generator
  always #25 clk = ~clk;

  // Compare and count
  task automatic check(input string n, input logic [35:0] s, e);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  // Register bus write and read
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {reg_addr, reg_wdata, reg_write} <= {a, d, 1'b1};
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  task automatic reg_chk(input logic [7:0] a, input logic [31:0] e,
                         input string n);
    @(posedge clk);
    {reg_addr, reg_read} <= {a, 1'b1};
    @(posedge clk);
    reg_read <= 1'b0;
    #1 check(n, {4'h0, reg_rdata}, {4'h0, e});
  endtask

  // Verdict and end of run
  task automatic print_verdict();
    if (fail_count == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (12000) @(posedge clk);
    fail_count++;
    print_verdict();
  end

  // Test sequence
  initial begin
    {reset, global_set_reset_n} = 2'b11;
    {reg_addr, reg_wdata, reg_write, reg_read} = '0;
    {init_load, init_addr, init_data} = '0;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    reg_chk(8'h00, 32'h0000_0000, "ctrl");
    reg_chk(8'h04, 32'h0010_0100, "level");
    reg_chk(8'h08, 32'h0003_0000, "status");
    reg_chk(8'h0c, 32'h0000_0000, "unmapped");
    // Byte lanes with parity bits, then the pipeline stage
    reg_wr(8'h00, 32'h0000_0028);
    i_pa.wr(14'h0007, 36'h1_2345_6789, 4'hf);
    i_pa.wr(14'h0007, 36'hf_edcb_a987, 4'h5);
    i_pa.rd(14'h0007, 0, q);
    check("bytes", q, (36'hf_edcb_a987 & M) | (36'h1_2345_6789 & ~M));
    reg_wr(8'h00, 32'h0000_0428);
    i_pa.wr(14'h0008, D, 4'hf);
    i_pa.rd(14'h0008, 0, q);
    check("pipe_early", q, (36'hf_edcb_a987 & M) | (36'h1_2345_6789 & ~M));
    @(posedge clk);
    #1 check("pipe_late", port_a_rdata, D);
    // Mixed widths over one array word
    reg_wr(8'h00, 32'h0000_00ea);
    i_pa.wr(14'h0000, D, 4'hf);
    for (int i = 0; i < 4; i++) begin
      i_pb.rd(14'(i), 0, q);
      check("x9_lane", q, (D >> (9 * i)) & 36'h0_0000_01ff);
    end
    reg_wr(8'h00, 32'h0000_002a);
    i_pb.rd(14'h0009, 0, q);
    check("x1_bit", q, {35'h0, D[10]});
    // Error-correcting words
    reg_wr(8'h00, 32'h0000_0228);
    i_pa.wr(14'h0003, 36'hf_a5a5_5a5a, 4'h1);
    i_pa.rd(14'h0003, 0, q);
    check("ecc_data", q, 36'h0_a5a5_5a5a);
    check("ecc_flags", {34'h0, port_a_single_err, port_a_double_err}, 36'h0);
    // True dual: port B writes a half word, port A reads it back
    reg_wr(8'h00, 32'h0000_0121);
    i_pb.wr(14'h0021, 36'h0_0002_b3c4, 4'h3);
    i_pa.rd(14'h0021, 0, q);
    check("tdp_b_to_a", q, 36'h0_0002_b3c4);
    // Preloaded read-only contents
    @(posedge clk);
    {init_load, init_addr, init_data} <= {1'b1, 9'h005, 36'h5_0505_0505};
    @(posedge clk);
    init_load <= 1'b0;
    reg_wr(8'h00, 32'h0000_096b);
    i_pa.wr(14'h0005, 36'h0, 4'hf);
    i_pa.rd(14'h0005, 0, q);
    check("rom", q, 36'h5_0505_0505);
    i_pb.rd(14'h0005, 1, q);
    // Local and global output clears
    i_pa.clear();
    #1 check("clr_a", port_a_rdata, 36'h0);
    check("keep_b", port_b_rdata, 36'h5_0505_0505);
    check("b_flags", {34'h0, port_b_single_err, port_b_double_err}, 36'h0);
    @(posedge clk);
    global_set_reset_n <= 1'b0;
    repeat (8) @(posedge clk);
    #1 check("gsr_b", port_b_rdata, 36'h0);
    @(posedge clk);
    global_set_reset_n <= 1'b1;
    repeat (5) @(posedge clk);
    // Buffer filled past full and drained past empty
    reg_wr(8'h00, 32'h0000_002c);
    reg_wr(8'h04, 32'h0200_0201);
    reg_chk(8'h04, 32'h0200_0201, "level_set");
    for (int i = 0; i < 512; i++) i_pa.wr(14'h0, 36'(i), 4'hf);
    @(posedge clk);
    #1 check("full", {35'h0, fifo_full}, 36'h1);
    i_pa.wr(14'h0, 36'h0_0000_dead, 4'hf);
    reg_chk(8'h08, 32'h0006_0200, "st_full");
    for (int i = 0; i < 512; i++) begin
      i_pb.rd(14'h0, 0, q);
      check("pop", q, 36'(i));
    end
    i_pb.rd(14'h0, 0, q);
    check("empty_pop", q, 36'd511);
    reg_chk(8'h08, 32'h0003_0000, "st_empty");
    print_verdict();
  end
endmodule
